// file: inc/iwd_pkg.sv
// Function
// - single word is 24 bits, 8-bit opcode on top
// - up to three opcodes, set in DWOP0-2, take two words
// - 48-bit pair; second word top byte zero
// - lone second word executes as no-operation
// - double-word instructions take two cycles
// - taken condition, branch, table read add cycles
// - taken skip costs two or three cycles
// - double-word moves take two cycles
// - file op result to file or working zero
// - multiply class names accumulator A or B
// - write-back only W13 direct or post-increment
// - word bit position is a 4-bit field
// - core flags carry, digit, negative, overflow, zero
// - overflow and saturate flags per accumulator
package iwd_pkg;
   // widths
   localparam int WORD_W = 24;
   localparam int OPC_W = 8;
   localparam int OPR_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CYC_W = 4;
   localparam int STALL_W = 2;
   localparam int CORE_FLAG_W = 5;
   localparam int DSP_FLAG_W = 4;
   localparam int BITPOS_W = 4;
   // fields of the program word
   localparam int OPC_MSB = 23;
   localparam int OPC_LSB = 16;
   localparam int CLS_MSB = 23;
   localparam int CLS_LSB = 20;
   localparam int FLD_DEST_BIT = 13;
   localparam int FLD_ACC_BIT = 15;
   localparam int FLD_AWB_MSB = 1;
   localparam int FLD_AWB_LSB = 0;
   localparam int FLD_BIT_MSB = 15;
   localparam int FLD_BIT_LSB = 12;
   localparam logic [1:0] AWB_DIRECT = 2'h0;
   localparam logic [1:0] AWB_POSTINC = 2'h1;
   // opcode groups
   localparam logic [OPC_W-1:0] OPC_NOP = 8'h00;
   localparam logic [3:0] CLS_CTRL = 4'h0;
   localparam logic [3:0] CLS_BIT = 4'hA;
   localparam logic [3:0] CLS_FILE = 4'hB;
   localparam logic [3:0] CLS_MAC = 4'hC;
   localparam logic [3:0] CLS_SKIP = 4'hD;
   // register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_DWOP0 = 8'h04;
   localparam logic [ADDR_W-1:0] REG_DWOP1 = 8'h08;
   localparam logic [ADDR_W-1:0] REG_DWOP2 = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] REG_COUNT = 8'h14;
   // control bits
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_ERRCLR_BIT = 1;
   localparam int CTRL_SATCLR_BIT = 2;
   // status layout
   localparam int STAT_CYC_LSB = 0;
   localparam int STAT_ERR_BIT = 4;
   localparam int STAT_BUSY_BIT = 5;
   localparam int STAT_CF_LSB = 8;
   localparam int STAT_DF_LSB = 16;
   // reset values and unit steps
   localparam logic RUN_RST = 1'b1;
   localparam logic [OPC_W-1:0] DWOP0_RST = 8'h02;
   localparam logic [OPC_W-1:0] DWOP1_RST = 8'h04;
   localparam logic [OPC_W-1:0] DWOP2_RST = 8'h07;
   localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;
   localparam logic [STALL_W-1:0] STALL_ONE = 2'h1;
   localparam logic [OPR_W-1:0] COUNT_ONE = 16'h0001;
   // core flag positions
   localparam int CF_C = 0;
   localparam int CF_DC = 1;
   localparam int CF_N = 2;
   localparam int CF_OV = 3;
   localparam int CF_Z = 4;
   // dsp flag positions
   localparam int DF_OA = 0;
   localparam int DF_OB = 1;
   localparam int DF_SA = 2;
   localparam int DF_SB = 3;

   typedef enum logic [2:0] {
      CL_CTRL, CL_WORD, CL_BIT, CL_FILE, CL_MAC, CL_SKIP
   } iwd_class_e;

   typedef enum logic [2:0] {
      ST_FETCH, ST_SECOND, ST_STALL, ST_SKIP1, ST_SKIP2
   } iwd_state_e;
endpackage : iwd_pkg

// file: rtl/iwd_flags.sv
`timescale 1ns/1ps
module iwd_flags (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // update strobes
   input wire logic core_upd,
   input wire logic dsp_upd,
   input wire logic sat_clr,
   // datapath results
   input wire logic [iwd_pkg::CORE_FLAG_W-1:0] core_res,
   input wire logic res_sticky_zero,
   input wire logic [iwd_pkg::DSP_FLAG_W-1:0] dsp_res,
   // flags
   output logic [iwd_pkg::CORE_FLAG_W-1:0] core_flags,
   output logic [iwd_pkg::DSP_FLAG_W-1:0] dsp_flags
);
   import iwd_pkg::*;

   logic [CORE_FLAG_W-1:0] core_r, core_nxt;
   logic [DSP_FLAG_W-1:0] dsp_r, dsp_nxt;
   wire logic zero_nxt;
   wire logic [1:0] sat_keep;

   // sticky zero only clears, never sets
   assign zero_nxt = res_sticky_zero ? (core_r[CF_Z] & core_res[CF_Z])
                                     : core_res[CF_Z];
   assign core_nxt = core_upd ? {zero_nxt, core_res[CF_OV:CF_C]}
                              : core_r;
   // saturation held until cleared; a new event beats the clear
   assign sat_keep = sat_clr ? 2'h0 : dsp_r[DF_SB:DF_SA];
   assign dsp_nxt = dsp_upd ?
      {sat_keep | dsp_res[DF_SB:DF_SA], dsp_res[DF_OB:DF_OA]}
      : {sat_keep, dsp_r[DF_OB:DF_OA]};

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         core_r <= '0;
         dsp_r <= '0;
      end else begin
         core_r <= core_nxt;
         dsp_r <= dsp_nxt;
      end
   end

   assign core_flags = core_r;
   assign dsp_flags = dsp_r;
endmodule : iwd_flags

// file: rtl/iwd_decoder.sv
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module iwd_decoder (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [iwd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [iwd_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [iwd_pkg::DATA_W-1:0] reg_rdata,
   // program word fetch
   input wire logic fetch_valid,
   input wire logic [iwd_pkg::WORD_W-1:0] fetch_word,
   output logic fetch_ready,
   // conditions for the word being fetched
   input wire logic ex_cond_true,
   input wire logic ex_pc_change,
   input wire logic ex_program_space_visibility,
   input wire logic ex_table_read,
   // datapath results
   input wire logic [iwd_pkg::CORE_FLAG_W-1:0] core_res,
   input wire logic res_sticky_zero,
   input wire logic [iwd_pkg::DSP_FLAG_W-1:0] dsp_res,
   // execution issue
   output logic exec_valid,
   output logic exec_nop,
   output logic exec_double,
   output logic [iwd_pkg::OPC_W-1:0] exec_opcode,
   output logic [iwd_pkg::OPR_W-1:0] exec_operand,
   output logic [iwd_pkg::OPR_W-1:0] exec_ext,
   output logic wb_to_file,
   output logic wb_to_default_working_register,
   output logic acc_second_accumulator,
   output logic awb_en,
   output logic awb_postinc,
   output logic [iwd_pkg::BITPOS_W-1:0] bit_pos,
   // status flags
   output logic [iwd_pkg::CORE_FLAG_W-1:0] core_flags,
   output logic [iwd_pkg::DSP_FLAG_W-1:0] dsp_flags
);
   import iwd_pkg::*;

   function automatic iwd_class_e op_class(input logic [WORD_W-1:0] w);
      logic [3:0] grp;
      iwd_class_e c;
      grp = w[CLS_MSB:CLS_LSB];
      c = CL_WORD;
      if (grp == CLS_CTRL) c = CL_CTRL;
      if (grp == CLS_BIT) c = CL_BIT;
      if (grp == CLS_FILE) c = CL_FILE;
      if (grp == CLS_MAC) c = CL_MAC;
      if (grp == CLS_SKIP) c = CL_SKIP;
      return c;
   endfunction : op_class

   function automatic logic is_double(
      input logic [OPC_W-1:0] op,
      input logic [OPC_W-1:0] d0,
      input logic [OPC_W-1:0] d1,
      input logic [OPC_W-1:0] d2
   );
      return (op != OPC_NOP) && (op == d0 || op == d1 || op == d2);
   endfunction : is_double

   // state
   iwd_state_e state_r, state_nxt;
   logic [STALL_W-1:0] stall_r, stall_nxt;
   logic [WORD_W-1:0] first_r;
   logic [CYC_W-1:0] cyc_r, cyc_nxt;
   logic [CYC_W-1:0] last_cyc_r;
   logic [OPR_W-1:0] count_r;
   logic fmt_err_r;

   // software registers
   logic run_r;
   logic [OPC_W-1:0] dwop0_r, dwop1_r, dwop2_r;
   logic [DATA_W-1:0] rdata_r;

   // issue registers
   logic exec_valid_r, exec_nop_r, exec_double_r;
   logic [OPC_W-1:0] exec_opcode_r;
   logic [OPR_W-1:0] exec_operand_r, exec_ext_r;
   logic wb_file_r, wb_wdef_r, acc_r, awb_en_r, awb_inc_r;
   logic [BITPOS_W-1:0] bit_pos_r;
   logic core_upd_r, dsp_upd_r;

   // fetch decode
   wire logic take;
   wire logic step;
   wire logic done;
   wire logic [OPC_W-1:0] in_opc;
   wire logic in_double;
   wire iwd_class_e in_class;
   wire logic skip_hit;
   wire logic [STALL_W-1:0] extra;
   wire logic in_squash;

   assign in_opc = fetch_word[OPC_MSB:OPC_LSB];
   assign in_double = is_double(in_opc, dwop0_r, dwop1_r, dwop2_r);
   assign in_class = op_class(fetch_word);
   assign take = fetch_valid & fetch_ready;
   assign step = take | (state_r == ST_STALL);
   assign done = step & (state_nxt == ST_FETCH);
   assign skip_hit = (in_class == CL_SKIP) & ex_cond_true;
   // one idle cycle for a taken test or jump, one for a data read
   assign extra = {1'b0, ex_cond_true | ex_pc_change}
                + {1'b0, ex_program_space_visibility | ex_table_read};
   assign in_squash = (state_r == ST_STALL) | (state_r == ST_SKIP1)
                    | (state_r == ST_SKIP2);

   // word handed to the datapath
   wire logic [WORD_W-1:0] dec_word;
   wire logic [OPC_W-1:0] dec_opc;
   wire iwd_class_e dec_class;
   wire logic [1:0] awb_fld;
   wire logic emit;
   wire logic emit_nop;
   wire logic dec_double;

   assign dec_double = (state_r == ST_SECOND);
   assign dec_word = dec_double ? first_r : fetch_word;
   assign dec_opc = dec_word[OPC_MSB:OPC_LSB];
   assign dec_class = op_class(dec_word);
   assign awb_fld = dec_word[FLD_AWB_MSB:FLD_AWB_LSB];
   // first word of a pair issues nothing; pair issues on its second cycle
   assign emit = step & ~((state_r == ST_FETCH) & in_double);
   // a lone second word carries a zero opcode and so does nothing
   assign emit_nop = in_squash | (dec_opc == OPC_NOP);

   // sequencer
   always_comb begin
      state_nxt = state_r;
      stall_nxt = stall_r;
      unique case (state_r)
         ST_FETCH: begin
            if (take) begin
               if (in_double) begin
                  state_nxt = ST_SECOND;
               end else if (skip_hit) begin
                  state_nxt = ST_SKIP1;
               end else if (extra != '0) begin
                  state_nxt = ST_STALL;
                  stall_nxt = extra;
               end
            end
         end
         ST_SECOND: begin
            if (take) begin
               state_nxt = ST_FETCH;
            end
         end
         ST_STALL: begin
            stall_nxt = stall_r - STALL_ONE;
            if (stall_r == STALL_ONE) begin
               state_nxt = ST_FETCH;
            end
         end
         ST_SKIP1: begin
            if (take) begin
               // a skipped pair costs one more cycle
               state_nxt = in_double ? ST_SKIP2 : ST_FETCH;
            end
         end
         ST_SKIP2: begin
            if (take) begin
               state_nxt = ST_FETCH;
            end
         end
      endcase
   end

   // new instructions wait for run; pending words always drain
   assign fetch_ready = (state_r == ST_STALL) ? 1'b0
                      : (state_r == ST_FETCH) ? run_r : 1'b1;

   assign cyc_nxt = done ? '0 : (step ? cyc_r + CYC_ONE : cyc_r);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= ST_FETCH;
         stall_r <= '0;
         cyc_r <= '0;
      end else begin
         state_r <= state_nxt;
         stall_r <= stall_nxt;
         cyc_r <= cyc_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         first_r <= '0;
      end else if (take & (state_r == ST_FETCH) & in_double) begin
         first_r <= fetch_word;
      end
   end

   // retired instruction bookkeeping
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         last_cyc_r <= '0;
         count_r <= '0;
      end else if (done) begin
         last_cyc_r <= cyc_r + CYC_ONE;
         count_r <= count_r + COUNT_ONE;
      end
   end

   // field decode for the issued word
   wire logic is_file;
   wire logic is_mac;
   wire logic is_bit;
   wire logic awb_sel_direct;
   wire logic awb_sel_inc;
   wire logic second_hi_bad;

   assign is_file = ~emit_nop & (dec_class == CL_FILE);
   assign is_mac = ~emit_nop & (dec_class == CL_MAC);
   assign is_bit = ~emit_nop & (dec_class == CL_BIT);
   assign awb_sel_direct = is_mac & (awb_fld == AWB_DIRECT);
   assign awb_sel_inc = is_mac & (awb_fld == AWB_POSTINC);
   // top byte of the second word must be clear
   assign second_hi_bad = take & dec_double
                        & (fetch_word[OPC_MSB:OPC_LSB] != OPC_NOP);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         exec_valid_r <= 1'b0;
         core_upd_r <= 1'b0;
         dsp_upd_r <= 1'b0;
      end else begin
         exec_valid_r <= emit;
         core_upd_r <= emit & ~emit_nop & (dec_class != CL_MAC)
                     & (dec_class != CL_CTRL);
         dsp_upd_r <= emit & is_mac;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         exec_nop_r <= 1'b1;
         exec_double_r <= 1'b0;
         exec_opcode_r <= OPC_NOP;
         exec_operand_r <= '0;
         exec_ext_r <= '0;
         wb_file_r <= 1'b0;
         wb_wdef_r <= 1'b0;
         acc_r <= 1'b0;
         awb_en_r <= 1'b0;
         awb_inc_r <= 1'b0;
         bit_pos_r <= '0;
      end else if (emit) begin
         exec_nop_r <= emit_nop;
         exec_double_r <= dec_double & ~emit_nop;
         exec_opcode_r <= emit_nop ? OPC_NOP : dec_opc;
         exec_operand_r <= dec_word[OPR_W-1:0];
         exec_ext_r <= dec_double ? fetch_word[OPR_W-1:0] : '0;
         wb_file_r <= is_file & dec_word[FLD_DEST_BIT];
         wb_wdef_r <= is_file & ~dec_word[FLD_DEST_BIT];
         acc_r <= is_mac & dec_word[FLD_ACC_BIT];
         awb_en_r <= awb_sel_direct | awb_sel_inc;
         awb_inc_r <= awb_sel_inc;
         bit_pos_r <= is_bit ? dec_word[FLD_BIT_MSB:FLD_BIT_LSB]
                             : '0;
      end
   end

   // register port decode
   wire logic wr_ctrl;
   wire logic err_clr;
   wire logic sat_clr;

   assign wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
   assign err_clr = wr_ctrl & reg_wdata[CTRL_ERRCLR_BIT];
   assign sat_clr = wr_ctrl & reg_wdata[CTRL_SATCLR_BIT];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         run_r <= RUN_RST;
         dwop0_r <= DWOP0_RST;
         dwop1_r <= DWOP1_RST;
         dwop2_r <= DWOP2_RST;
      end else if (reg_wr) begin
         if (reg_addr == REG_CTRL) begin
            run_r <= reg_wdata[CTRL_RUN_BIT];
         end
         if (reg_addr == REG_DWOP0) begin
            dwop0_r <= reg_wdata[OPC_W-1:0];
         end
         if (reg_addr == REG_DWOP1) begin
            dwop1_r <= reg_wdata[OPC_W-1:0];
         end
         if (reg_addr == REG_DWOP2) begin
            dwop2_r <= reg_wdata[OPC_W-1:0];
         end
      end
   end

   // format error: a new event beats the clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fmt_err_r <= 1'b0;
      end else begin
         fmt_err_r <= second_hi_bad | (fmt_err_r & ~err_clr);
      end
   end

   wire logic [DATA_W-1:0] stat_word;
   wire logic [DATA_W-1:0] rd_sel;

   assign stat_word = (DATA_W'(last_cyc_r) << STAT_CYC_LSB)
                    | (DATA_W'(fmt_err_r) << STAT_ERR_BIT)
                    | (DATA_W'(state_r != ST_FETCH) << STAT_BUSY_BIT)
                    | (DATA_W'(core_flags) << STAT_CF_LSB)
                    | (DATA_W'(dsp_flags) << STAT_DF_LSB);

   assign rd_sel = (reg_addr == REG_CTRL) ? DATA_W'(run_r)
                 : (reg_addr == REG_DWOP0) ? DATA_W'(dwop0_r)
                 : (reg_addr == REG_DWOP1) ? DATA_W'(dwop1_r)
                 : (reg_addr == REG_DWOP2) ? DATA_W'(dwop2_r)
                 : (reg_addr == REG_STAT) ? stat_word
                 : (reg_addr == REG_COUNT) ? DATA_W'(count_r)
                 : '0;

   // read data stands for one cycle only
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= reg_rd ? rd_sel : '0;
      end
   end

   iwd_flags u_flags (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .core_upd(core_upd_r),
      .dsp_upd(dsp_upd_r),
      .sat_clr(sat_clr),
      .core_res(core_res),
      .res_sticky_zero(res_sticky_zero),
      .dsp_res(dsp_res),
      .core_flags(core_flags),
      .dsp_flags(dsp_flags)
   );

   assign reg_rdata = rdata_r;
   assign exec_valid = exec_valid_r;
   assign exec_nop = exec_nop_r;
   assign exec_double = exec_double_r;
   assign exec_opcode = exec_opcode_r;
   assign exec_operand = exec_operand_r;
   assign exec_ext = exec_ext_r;
   assign wb_to_file = wb_file_r;
   assign wb_to_default_working_register = wb_wdef_r;
   assign acc_second_accumulator = acc_r;
   assign awb_en = awb_en_r;
   assign awb_postinc = awb_inc_r;
   assign bit_pos = bit_pos_r;
endmodule : iwd_decoder

// file: bench/iwd_decoder_assertions.sv
`timescale 1ns/1ps
module iwd_decoder_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // register writes
   input wire logic [iwd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [iwd_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   // fetch side
   input wire logic fetch_valid,
   input wire logic [iwd_pkg::WORD_W-1:0] fetch_word,
   input wire logic fetch_ready,
   input wire logic ex_cond_true,
   input wire logic ex_table_read,
   // issue side
   input wire logic exec_valid,
   input wire logic exec_nop,
   input wire logic exec_double,
   input wire logic [iwd_pkg::OPC_W-1:0] exec_opcode,
   input wire logic [iwd_pkg::OPR_W-1:0] exec_operand,
   input wire logic [iwd_pkg::OPR_W-1:0] exec_ext,
   input wire logic wb_to_file,
   input wire logic wb_to_default_working_register,
   input wire logic acc_second_accumulator,
   input wire logic awb_en,
   input wire logic awb_postinc,
   input wire logic [iwd_pkg::BITPOS_W-1:0] bit_pos,
   input wire logic [iwd_pkg::DSP_FLAG_W-1:0] dsp_flags
);
   import iwd_pkg::*;
   logic pend_r;
   logic skip_r;
   wire take = fetch_valid && fetch_ready;
   wire [OPC_W-1:0] opc = fetch_word[OPC_MSB:OPC_LSB];
   wire is_dw = opc inside {DWOP0_RST, DWOP1_RST, DWOP2_RST};
   wire sgl = take && !pend_r && !skip_r && !is_dw && opc != OPC_NOP;
   wire real_iss = exec_valid && !exec_nop;
   wire [3:0] cls = exec_opcode[7:4];
   wire [1:0] awb_fld = exec_operand[FLD_AWB_MSB:FLD_AWB_LSB];
   wire sat_clr = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_SATCLR_BIT];

   // first word of a pair pending, or word in a taken skip's shadow
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pend_r <= 1'b0;
         skip_r <= 1'b0;
      end else if (take) begin
         pend_r <= !pend_r && !skip_r && is_dw;
         skip_r <= !pend_r && !skip_r && opc[7:4] == CLS_SKIP && ex_cond_true;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_real;
      exec_valid && !exec_nop;
   endsequence
   sequence s_fill;
      exec_valid && exec_nop;
   endsequence

   a_single_issue: assert property (sgl |=> real_iss && !exec_double
      && exec_opcode == $past(opc) && exec_operand == $past(fetch_word[15:0]))
      else $error("single word not issued");
   a_pair_issue: assert property (take && pend_r |=> exec_valid
      && exec_double && exec_ext == $past(fetch_word[15:0]))
      else $error("word pair not issued");
   a_lone_second: assert property (take && !pend_r && opc == OPC_NOP
      |=> s_fill ##0 exec_opcode == OPC_NOP)
      else $error("lone second word not a no-operation");
   a_extra_fill: assert property (sgl && opc[7:4] == CLS_FILE
      && ex_cond_true && ex_table_read |=> s_real ##1 s_fill[*2])
      else $error("extra cycles not filled");
   a_file_dest: assert property (real_iss && cls == CLS_FILE |->
      wb_to_file == exec_operand[FLD_DEST_BIT]
      && wb_to_default_working_register == !exec_operand[FLD_DEST_BIT])
      else $error("file write-back target wrong");
   a_acc_pick: assert property (real_iss && cls == CLS_MAC |->
      acc_second_accumulator == exec_operand[FLD_ACC_BIT])
      else $error("accumulator choice wrong");
   a_awb_target: assert property (real_iss && cls == CLS_MAC |->
      awb_en == (awb_fld <= AWB_POSTINC)
      && awb_postinc == (awb_fld == AWB_POSTINC))
      else $error("write-back target wrong");
   a_bit_field: assert property (real_iss && cls == CLS_BIT |->
      bit_pos == exec_operand[FLD_BIT_MSB:FLD_BIT_LSB])
      else $error("bit position wrong");
   a_sat_hold: assert property ($fell(dsp_flags[DF_SA]) |->
      $past(sat_clr))
      else $error("saturate flag dropped without clear");
endmodule : iwd_decoder_checker

bind iwd_decoder iwd_decoder_checker u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .fetch_valid(fetch_valid),
   .fetch_word(fetch_word), .fetch_ready(fetch_ready),
   .ex_cond_true(ex_cond_true), .ex_table_read(ex_table_read),
   .exec_valid(exec_valid), .exec_nop(exec_nop), .exec_double(exec_double),
   .exec_opcode(exec_opcode), .exec_operand(exec_operand),
   .exec_ext(exec_ext), .wb_to_file(wb_to_file),
   .wb_to_default_working_register(wb_to_default_working_register),
   .acc_second_accumulator(acc_second_accumulator), .awb_en(awb_en),
   .awb_postinc(awb_postinc), .bit_pos(bit_pos), .dsp_flags(dsp_flags)
);

// file: bench/iwd_fetch_model.sv
`timescale 1ns/1ps
module iwd_fetch_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // fetch handshake
   input wire logic fetch_ready,
   output logic fetch_valid,
   output logic [iwd_pkg::WORD_W-1:0] fetch_word,
   // conditions of the offered word
   output logic ex_cond_true,
   output logic ex_pc_change,
   output logic ex_program_space_visibility,
   output logic ex_table_read
);
   import iwd_pkg::*;
   logic [27:0] q[$];
   logic [27:0] last_r = '0;

   task push(input logic [WORD_W-1:0] w, input logic [3:0] c);
      q.push_back({c, w});
   endtask : push

   always @(posedge core_clk) begin
      if (!sys_rst && fetch_valid && fetch_ready) begin
         last_r = q.pop_front();
      end
      if (!sys_rst && q.size() != 0) begin
         fetch_valid <= 1'b1;
         {ex_cond_true, ex_pc_change, ex_program_space_visibility,
            ex_table_read, fetch_word} <= q[0];
      end else begin
         fetch_valid <= 1'b0;
         // released lines carry stale garbage, not the last word
         {ex_cond_true, ex_pc_change, ex_program_space_visibility,
            ex_table_read, fetch_word} <= ~last_r;
      end
   end
endmodule : iwd_fetch_model

// file: bench/iwd_decoder_tb.sv
`timescale 1ns/1ps
module iwd_decoder_tb;
   import iwd_pkg::*;
   localparam logic [50:0] MB = 51'h7_FFFF_FFFF_FE00;
   localparam logic [50:0] MN = 51'h7_FE00_0000_0000;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [CORE_FLAG_W-1:0] core_res = 5'h0B;
   logic res_sticky_zero = 1'b0;
   logic [DSP_FLAG_W-1:0] dsp_res = 4'h5;
   logic [DATA_W-1:0] reg_rdata;
   logic [WORD_W-1:0] fw;
   logic fv, fr, ct, pc, ps, tr;
   logic ev_v, ev_n, ev_d, wbf, wbw, acc, awe, awp;
   logic [OPC_W-1:0] e_op;
   logic [OPR_W-1:0] e_opr, e_ext;
   logic [BITPOS_W-1:0] bp;
   logic [CORE_FLAG_W-1:0] cflg;
   logic [DSP_FLAG_W-1:0] dflg;
   logic [50:0] iss[$];
   int fails = 0;
   int compares = 0;

   always #2 core_clk = ~core_clk;

   iwd_fetch_model fm (.core_clk(core_clk), .sys_rst(sys_rst),
      .fetch_ready(fr), .fetch_valid(fv), .fetch_word(fw),
      .ex_cond_true(ct), .ex_pc_change(pc),
      .ex_program_space_visibility(ps), .ex_table_read(tr));

   iwd_decoder dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_valid(fv),
      .fetch_word(fw), .fetch_ready(fr), .ex_cond_true(ct),
      .ex_pc_change(pc), .ex_program_space_visibility(ps),
      .ex_table_read(tr), .core_res(core_res),
      .res_sticky_zero(res_sticky_zero), .dsp_res(dsp_res),
      .exec_valid(ev_v), .exec_nop(ev_n), .exec_double(ev_d),
      .exec_opcode(e_op), .exec_operand(e_opr), .exec_ext(e_ext),
      .wb_to_file(wbf), .wb_to_default_working_register(wbw),
      .acc_second_accumulator(acc), .awb_en(awe), .awb_postinc(awp),
      .bit_pos(bp), .core_flags(cflg), .dsp_flags(dflg));

   // record every issued cycle
   always @(posedge core_clk) begin
      if (!sys_rst && ev_v) begin
         iss.push_back({ev_n, ev_d, e_op, e_opr, e_ext, wbf, wbw, acc, awe,
            awp, bp});
      end
   end

   task chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rdc(input logic [ADDR_W-1:0] a, input logic [31:0] m,
      input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & m, e);
   endtask : rdc

   task xp(input logic [50:0] m, input logic [50:0] e);
      int k;
      for (k = 0; k < 40 && iss.size() == 0; k++) @(posedge core_clk);
      if (iss.size() == 0) chk(64'h0, 64'h1);
      else chk(iss.pop_front() & m, e & m);
   endtask : xp

   task t_regs;
      rdc(REG_CTRL, 32'h0000_0001, 32'h0000_0001);
      rdc(REG_DWOP0, 32'hFFFF_FFFF, 32'h0000_0002);
      rdc(REG_DWOP1, 32'hFFFF_FFFF, 32'h0000_0004);
      rdc(REG_DWOP2, 32'hFFFF_FFFF, 32'h0000_0007);
      wr(8'h18, 32'hFFFF_FFFF);
      rdc(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0000);
      #1 chk(fr, 1'b0);
      wr(REG_CTRL, 32'h0000_0001);
   endtask : t_regs

   task t_file;
      fm.push(24'hB1_2000, 4'h0);
      fm.push(24'hB2_0005, 4'h0);
      xp(MB | 51'h180, {10'h0B1, 16'h2000, 16'h0, 9'h100});
      xp(MB | 51'h180, {10'h0B2, 16'h0005, 16'h0, 9'h080});
      rdc(REG_STAT, 32'h0000_1F0F, 32'h0000_0B01);
      chk(cflg, 5'h0B);
   endtask : t_file

   task t_mac_bit;
      fm.push(24'hC0_8001, 4'h0);
      fm.push(24'hC1_0000, 4'h0);
      fm.push(24'hC2_0003, 4'h0);
      fm.push(24'hA0_F000, 4'h0);
      fm.push(24'hA3_0000, 4'h0);
      xp(MB | 51'h070, {10'h0C0, 16'h8001, 16'h0, 9'h070});
      xp(MB | 51'h070, {10'h0C1, 16'h0000, 16'h0, 9'h020});
      xp(MB | 51'h070, {10'h0C2, 16'h0003, 16'h0, 9'h000});
      xp(MB | 51'h00F, {10'h0A0, 16'hF000, 16'h0, 9'h00F});
      xp(MB | 51'h00F, {10'h0A3, 16'h0000, 16'h0, 9'h000});
      chk(dflg, 4'h5);
      wr(REG_CTRL, 32'h0000_0005);
      #1 chk(dflg, 4'h1);
   endtask : t_mac_bit

   task t_dbl;
      logic [7:0] ops [3];
      ops = '{8'h02, 8'h04, 8'h07};
      foreach (ops[i]) begin
         fm.push({ops[i], 16'h1234}, 4'h0);
         fm.push(24'h00_5678, 4'h0);
         xp(MB, {2'b01, ops[i], 16'h1234, 16'h5678, 9'h0});
         rdc(REG_STAT, 32'h0000_000F, 32'h0000_0002);
         fm.push(24'h00_9ABC, 4'h0);
         xp(MN, 51'h4_0000_0000_0000);
      end
   endtask : t_dbl

   task t_extra;
      res_sticky_zero <= 1'b1;
      core_res <= 5'h1F;
      fm.push(24'hB0_0001, 4'h9);
      xp(MB, {10'h0B0, 16'h0001, 16'h0, 9'h0});
      xp(MN, 51'h4_0000_0000_0000);
      xp(MN, 51'h4_0000_0000_0000);
      rdc(REG_STAT, 32'h0000_000F, 32'h0000_0003);
      fm.push(24'hB0_0002, 4'h4);
      xp(MB, {10'h0B0, 16'h0002, 16'h0, 9'h0});
      xp(MN, 51'h4_0000_0000_0000);
      rdc(REG_STAT, 32'h0000_000F, 32'h0000_0002);
      chk(cflg, 5'h0F);
   endtask : t_extra

   task t_skip;
      int n;
      for (n = 2; n <= 3; n++) begin
         fm.push(24'hD0_0000, 4'h8);
         if (n == 3) fm.push(24'h04_1111, 4'h0);
         else fm.push(24'hB0_1111, 4'h0);
         if (n == 3) fm.push(24'h00_2222, 4'h0);
         xp(MB, {10'h0D0, 16'h0, 16'h0, 9'h0});
         repeat (n - 1) xp(MN, 51'h4_0000_0000_0000);
         rdc(REG_STAT, 32'h0000_000F, n);
      end
   endtask : t_skip

   task summarize;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize

   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_file;
      t_mac_bit;
      t_dbl;
      t_extra;
      t_skip;
      summarize;
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      summarize;
   end
endmodule : iwd_decoder_tb
